//--- core/ddr3_pin_if.sv
// Device end of a DDR3 pin interface: command decode, bank and power
// state, mode registers, burst data path, termination control.
// Assumes the controller clock arrives as ck_in; the user side of the
// command report runs on core_clk_in.
//
// Behaviour
// - ACTIVATE takes row, READ/WRITE column; A10 requests auto precharge.
// - PRECHARGE with A10 low closes the addressed bank, high closes all.
// - With on-the-fly chop enabled, A12 high gives eight beats, low four.
// - Bank address picks the bank of ACTIVATE, READ, WRITE and PRECHARGE.
// - LOAD MODE loads the address op-code into the register named by bank.
// - Control and address inputs are sampled on the rising clock crossing.
// - Output data strobe is timed from the input clock crossings.
// - CKE low enters precharge or active power-down, or self refresh.
// - CKE is synchronous, except for the asynchronous self-refresh exit.
// - Power-down hears clock, CKE, reset, ODT; self refresh CKE, reset.
// - Chip select high masks all commands; low enables the decoder.
// - Command comes from chip select, RAS, CAS and WE on one edge.
// - A high lower mask leaves that write beat's lower byte unwritten.
// - Registered ODT terminates data, strobe, mask; mode may disable it.
// - Read strobe edge-aligned with data; controller centres write strobe.
// - Byte-wide only: termination strobe disables masking and terminates.
// - Reset is active low; assertion acts asynchronously, release takes effect at the next rising clock.
`timescale 1ns/1ps
module ddr3_pin_if #(
  parameter int DQ_W   = 8,
  parameter int ADDR_W = 14
) (
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        ck_in,
  input  wire logic                        reset_n_in,
  input  wire logic                        cke_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        ras_n_in,
  input  wire logic                        cas_n_in,
  input  wire logic                        we_n_in,
  input  wire logic [2:0]                  ba_in,
  input  wire logic [ADDR_W-1:0]           addr_in,
  input  wire logic                        odt_in,
  input  wire logic [(DQ_W==16 ? 2:1)-1:0] dm_in,
  input  wire logic [DQ_W-1:0]             dq_in,
  output logic      [DQ_W-1:0]             dq_out,
  output logic                             dq_oe_out,
  output logic                             dqs_out,
  output logic                             dqs_n_out,
  output logic                             dqs_oe_out,
  output logic                             term_en_out,
  output logic                             tdqs_term_out,
  input  wire logic [DQ_W-1:0]             rd_data_in,
  output logic      [DQ_W-1:0]             wr_data_out,
  output logic      [(DQ_W==16 ? 2:1)-1:0] wr_be_out,
  output logic                             wr_valid_out,
  output logic                             cmd_valid_out,
  output ddr3_pin_pkg::cmd_t               cmd_kind_out,
  output logic      [2:0]                  cmd_bank_out,
  output logic      [ADDR_W-1:0]           cmd_addr_out,
  output logic                             cmd_ap_out,
  output logic                             cmd_chop_out,
  output ddr3_pin_pkg::pwr_t               pwr_state_out
);
  import ddr3_pin_pkg::*;

  localparam int DM_W = (DQ_W == 16) ? 2 : 1;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (!(DQ_W == 4 || DQ_W == 8 || DQ_W == 16)) begin : g_bad_width
    $error("DQ_W must be 4, 8 or 16");
  end
  if (ADDR_W < MIN_ADDR_W) begin : g_bad_addr
    $error("ADDR_W too small for A10 and A12");
  end

  // ----------------------------------------------------------------
  // Link-side state, clocked by the controller clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_BANKS-1:0]              open;
    logic [NUM_MR-1:0][ADDR_W-1:0]     mr;
    pwr_t                              pwr;
    logic [3:0]                        beats;
    logic                              rd;
    logic                              wr;
    logic                              tog;
    cmd_t                              kind;
    logic [BANK_W-1:0]                 bank;
    logic [ADDR_W-1:0]                 addr;
    logic                              ap;
    logic                              chop;
    logic [DQ_W-1:0]                   dq;
    logic                              dq_oe;
    logic                              dqs;
    logic                              term;
    logic                              tdqs_term;
    logic [DQ_W-1:0]                   wdata;
    logic [DM_W-1:0]                   wbe;
    logic                              wvalid;
  } link_t;

  link_t  q;
  link_t  nxt_q;
  logic   self_ref_ff;
  logic   sr_set;
  logic   live;
  logic   chop;
  logic   rtt_on;
  logic   tdqs_on;
  cmd_t   cmd;
  pwr_t   pwr_view;

  // Decoder only listens while awake, selected and clock enabled
  assign live = (q.pwr == PWR_ON) && !self_ref_ff && cke_in;
  assign cmd  = cs_n_in ? CMD_NOP
              : cmd_t'({ras_n_in, cas_n_in, we_n_in});

  // Burst length: mode picks fixed or pin-selected length
  always_comb begin
    case (q.mr[MR_BURST][BL_MSB:BL_LSB])
      BL_OTF:    chop = !addr_in[BC_BIT];
      BL_FIXED4: chop = 1'b1;
      default:   chop = 1'b0;
    endcase
  end

  assign rtt_on  = q.mr[MR_TERM][RTT_B2] | q.mr[MR_TERM][RTT_B1]
                 | q.mr[MR_TERM][RTT_B0];
  assign tdqs_on = (DQ_W == 8) && q.mr[MR_TERM][TDQS_BIT];
  assign pwr_view = self_ref_ff ? PWR_SR : q.pwr;

  // Next link state: power, command, burst and termination
  always_comb begin
    nxt_q        = q;
    nxt_q.wvalid = 1'b0;
    sr_set       = 1'b0;
    // Power-down entry and exit are synchronous to the clock
    if (!self_ref_ff) begin
      if (q.pwr != PWR_ON) begin
        if (cke_in) begin
          nxt_q.pwr = PWR_ON;
        end
      end else if (!cke_in) begin
        if (q.open != '0) begin
          nxt_q.pwr = PWR_APD;
        end else if (cmd == CMD_REF) begin
          sr_set = 1'b1;
        end else begin
          nxt_q.pwr = PWR_PPD;
        end
      end
    end
    // Burst beats: reads drive pins, writes capture them
    if (q.beats != 4'h0) begin
      nxt_q.beats = q.beats - 4'h1;
      if (q.wr) begin
        nxt_q.wvalid = 1'b1;
        nxt_q.wdata  = dq_in;
        nxt_q.wbe    = tdqs_on ? {DM_W{1'b1}} : ~dm_in;
        // A write cutting into a read must release the bus at once
        nxt_q.dq_oe  = 1'b0;
        nxt_q.dqs    = 1'b0;
      end else if (q.rd) begin
        nxt_q.dq    = rd_data_in;
        nxt_q.dq_oe = 1'b1;
        nxt_q.dqs   = ~q.dqs;  // Toggles with each beat: edge aligned
      end
    end else begin
      nxt_q.dq_oe = 1'b0;
      nxt_q.dqs   = 1'b0;
    end
    // Command execution
    if (live && cmd != CMD_NOP) begin
      nxt_q.tog  = ~q.tog;
      nxt_q.kind = cmd;
      nxt_q.bank = ba_in;
      nxt_q.addr = addr_in;
      nxt_q.ap   = 1'b0;
      nxt_q.chop = 1'b0;
      case (cmd)
        CMD_ACT: nxt_q.open[ba_in] = 1'b1;
        CMD_PRE: begin
          if (addr_in[AP_BIT]) begin
            nxt_q.open = '0;
          end else begin
            nxt_q.open[ba_in] = 1'b0;
          end
        end
        CMD_MRS: begin
          if (!ba_in[BANK_W-1]) begin
            nxt_q.mr[ba_in[MR_SEL_W-1:0]] = addr_in;
          end
        end
        CMD_RD, CMD_WR: begin
          nxt_q.beats = chop ? BEATS_4 : BEATS_8;
          nxt_q.rd    = (cmd == CMD_RD);
          nxt_q.wr    = (cmd == CMD_WR);
          nxt_q.chop  = chop;
          nxt_q.ap    = addr_in[AP_BIT];
          // Bank is marked closed at once; recovery is the
          // controller's timing to keep
          if (addr_in[AP_BIT]) begin
            nxt_q.open[ba_in] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // ODT is still heard in power-down but not in self refresh
    nxt_q.term      = odt_in && rtt_on && !self_ref_ff;
    nxt_q.tdqs_term = odt_in && rtt_on && !self_ref_ff
                    && tdqs_on;
  end

  // Link register; reset pin acts without the clock
  always_ff @(posedge ck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  // Self refresh flag: leaves on CKE alone since the clock may be
  // stopped. The controller must restart the clock before raising CKE
  // so that the decoder sees a settled flag.
  always_ff @(posedge ck_in or negedge reset_n_in or posedge cke_in) begin
    if (!reset_n_in) begin
      self_ref_ff <= 1'b0;
    end else if (cke_in) begin
      self_ref_ff <= 1'b0;
    end else if (sr_set) begin
      self_ref_ff <= 1'b1;
    end
  end

  // Pin and user outputs straight from link flops
  assign dq_out        = q.dq;
  assign dq_oe_out     = q.dq_oe;
  assign dqs_out       = q.dqs;
  assign dqs_n_out     = ~q.dqs;
  assign dqs_oe_out    = q.dq_oe;
  assign term_en_out   = q.term;
  assign tdqs_term_out = q.tdqs_term;
  assign wr_data_out   = q.wdata;
  assign wr_be_out     = q.wbe;
  assign wr_valid_out  = q.wvalid;

  // ----------------------------------------------------------------
  // Core-side report of commands and power state
  // ----------------------------------------------------------------
  // The command word is held by the link until the next command, and a
  // toggle marks each new one. Commands closer than about five link
  // clocks may be merged into the latest one.
  typedef struct packed {
    logic              tog1;
    logic              tog2;
    logic              tog3;
    logic              seen;
    pwr_t              pw1;
    pwr_t              pw2;
    pwr_t              pw3;
    pwr_t              pwr;
    logic              valid;
    cmd_t              kind;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic              ap;
    logic              chop;
  } core_t;

  core_t c;
  core_t nxt_c;

  // Three-stage synchronisers; a change counts when stages two and
  // three agree
  always_comb begin
    nxt_c       = c;
    nxt_c.valid = 1'b0;
    nxt_c.tog1  = q.tog;
    nxt_c.tog2  = c.tog1;
    nxt_c.tog3  = c.tog2;
    nxt_c.pw1   = pwr_view;
    nxt_c.pw2   = c.pw1;
    nxt_c.pw3   = c.pw2;
    if (c.tog2 == c.tog3 && c.tog3 != c.seen) begin
      nxt_c.seen  = c.tog3;
      nxt_c.valid = 1'b1;
      nxt_c.kind  = q.kind;
      nxt_c.bank  = q.bank;
      nxt_c.addr  = q.addr;
      nxt_c.ap    = q.ap;
      nxt_c.chop  = q.chop;
    end
    // Awake to active power-down flips two bits; a brief wrong
    // intermediate value is held off, since stages two and three must agree
    if (c.pw2 == c.pw3) begin
      nxt_c.pwr = c.pw3;
    end
  end

  // Core register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      c <= '0;
    end else begin
      c <= nxt_c;
    end
  end

  assign cmd_valid_out = c.valid;
  assign cmd_kind_out  = c.kind;
  assign cmd_bank_out  = c.bank;
  assign cmd_addr_out  = c.addr;
  assign cmd_ap_out    = c.ap;
  assign cmd_chop_out  = c.chop;
  assign pwr_state_out = c.pwr;

  // ----------------------------------------------------------------
  // Checks on the link domain
  // ----------------------------------------------------------------
  default clocking cb_link @(posedge ck_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_act;
    live && cmd == CMD_ACT;
  endsequence
  sequence s_masked_beat;
    q.beats != 4'h0 && q.wr && dm_in[0] && !tdqs_on;
  endsequence
  sequence s_read_beat;
    q.dq_oe ##1 q.dq_oe;
  endsequence

  chk_cs_masks: assert property (cs_n_in |=> $stable(q.tog))
    else $error("command taken while deselected");
  chk_act_opens: assert property (
    s_act |=> q.open[$past(ba_in)])
    else $error("activate left bank closed");
  chk_pre_all: assert property (
    live && cmd == CMD_PRE && addr_in[AP_BIT] |=> q.open == '0)
    else $error("precharge all left a bank open");
  chk_mode_load: assert property (
    live && cmd == CMD_MRS && !ba_in[BANK_W-1]
    |=> q.mr[$past(ba_in[MR_SEL_W-1:0])] == $past(addr_in))
    else $error("mode register not loaded");
  chk_otf_chop: assert property (
    live && (cmd == CMD_RD || cmd == CMD_WR)
    && q.mr[MR_BURST][BL_MSB:BL_LSB] == BL_OTF && !addr_in[BC_BIT]
    |=> q.beats == BEATS_4)
    else $error("chopped burst not four beats");
  chk_lower_mask: assert property (
    s_masked_beat |=> wr_valid_out && !wr_be_out[0])
    else $error("masked lower byte written");
  chk_read_strobe: assert property (
    s_read_beat |-> dqs_out != $past(dqs_out))
    else $error("strobe not toggling with read data");
  chk_apd_entry: assert property (
    q.pwr == PWR_ON && !self_ref_ff && !cke_in && q.open != '0
    |=> q.pwr == PWR_APD)
    else $error("active power-down not entered");
  chk_pd_freeze: assert property (
    q.pwr != PWR_ON && !cke_in |=> $stable(q.open) [*2])
    else $error("bank state moved in power-down");
  chk_odt_off: assert property (!rtt_on |=> !term_en_out)
    else $error("termination on while disabled");

endmodule : ddr3_pin_if

//--- core/ddr3_pin_pkg.sv
// Shared constants and types of the DDR3 pin command interface.
// Assumes three users: the device-side pin interface module, the controller model and the bench.
package ddr3_pin_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int BANK_W    = 3;
  localparam int NUM_MR    = 4;
  localparam int MR_SEL_W  = 2;
  localparam int MIN_ADDR_W = 13;

  // ----------------------------------------------------------------
  // Address bit roles
  // ----------------------------------------------------------------
  localparam int AP_BIT = 10;  // Auto precharge / precharge-all
  localparam int BC_BIT = 12;  // On-the-fly burst chop, low = chop

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MR_BURST   = 0;
  localparam int MR_TERM    = 1;
  localparam int BL_LSB     = 0;
  localparam int BL_MSB     = 1;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam int RTT_B0   = 2;  // Any termination bit set enables ODT
  localparam int RTT_B1   = 6;
  localparam int RTT_B2   = 9;
  localparam int TDQS_BIT = 11;

  // ----------------------------------------------------------------
  // Burst lengths in beats
  // ----------------------------------------------------------------
  localparam logic [3:0] BEATS_8 = 4'h8;
  localparam logic [3:0] BEATS_4 = 4'h4;

  // Command code is {ras_n, cas_n, we_n} with chip select low
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_ZQ  = 3'h6,
    CMD_NOP = 3'h7
  } cmd_t;

  // Power states; awake to power-down is the usual path
  typedef enum logic [1:0] {
    PWR_ON  = 2'h0,
    PWR_PPD = 2'h1,
    PWR_APD = 2'h3,
    PWR_SR  = 2'h2
  } pwr_t;

endpackage : ddr3_pin_pkg

//--- tb/ddr3_ctl_model.sv
// Controller model driving the device's command, address and data pins.
// Assumes ck_in runs freely from the bench; pins move on its fall.
`timescale 1ns/1ps
module ddr3_ctl_model (
  input  wire logic   ck_in,
  output logic        reset_n_out,
  output logic        cke_out,
  output logic        cs_n_out,
  output logic [2:0]  cmd_out,
  output logic [2:0]  ba_out,
  output logic [13:0] addr_out,
  output logic        odt_out,
  output logic        dm_out,
  output logic [7:0]  dq_out
);
  import ddr3_pin_pkg::*;

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Idle pins at time zero; device held in reset
  initial begin
    reset_n_out = 1'b0;
    cke_out = 1'b0;
    cs_n_out = 1'b1;
    cmd_out = 3'h7;
    ba_out = 3'h0;
    addr_out = 14'h0000;
    odt_out = 1'b0;
    dm_out = 1'b0;
    dq_out = 8'h00;
  end

  // One command slot, half a cycle of setup before the sampling rise
  task automatic issue(input logic sel_n, input cmd_t c,
                       input logic [2:0] b, input logic [13:0] a,
                       input logic k);
    @(negedge ck_in);
    cs_n_out = sel_n;
    cmd_out = c;
    ba_out = b;
    addr_out = a;
    cke_out = k;
  endtask : issue

  // Deselected slot with one data beat; command and address lines are scrambled
  // so a device reading them outside a command is caught
  task automatic beat(input logic [7:0] d, input logic m);
    @(negedge ck_in);
    cs_n_out = 1'b1;
    cmd_out = ~cmd_out;
    addr_out = ~addr_out;
    dq_out = d;
    dm_out = m;
  endtask : beat

  task automatic nop();
    beat(~dq_out, ~dm_out);
  endtask : nop

  // Level pins: reset, clock enable, termination request
  task automatic pins(input logic r, input logic k, input logic o);
    @(negedge ck_in);
    reset_n_out = r;
    cke_out = k;
    odt_out = o;
  endtask : pins
endmodule : ddr3_ctl_model

//--- tb/ddr3_pin_command_interface_tb_top.sv
// Bench for the DDR3 pin interface: controller model on the link,
// report and power checks on the core side.
// Assumes the package and device module are compiled first.
`timescale 1ns/1ps
module ddr3_pin_command_interface_tb_top;
  import ddr3_pin_pkg::*;

  // ---------------------------------------------------------------
  // Clocks, wires and observers
  // ---------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        ck = 1'b0;
  logic        rst = 1'b1;
  logic        rst_n, cke, cs_n, odt, dm, dq_oe, dqs, dqs_n, dqs_oe;
  logic        term, tdqs, wr_valid, wr_be, cmd_valid, cmd_ap, cmd_chop;
  logic [2:0]  cmd, ba, cmd_bank;
  logic [13:0] addr, cmd_addr;
  logic [7:0]  dq, dq_o, wr_data;
  logic [7:0]  rd_pat = 8'h5a;
  cmd_t        cmd_kind;
  pwr_t        pwr;
  int          err_count = 0;
  int          samples_checked = 0;
  int          rcnt = 0;
  int          rbad = 0;
  logic        dqs_prev = 1'b0;
  logic [8:0]  wq[$];

  // Link rising edges fall on odd nanoseconds, clear of every core edge
  always #4 core_clk = ~core_clk;
  always #3 ck = ~ck;

  ddr3_pin_if #(.DQ_W(8), .ADDR_W(14)) dut (
    .core_clk_in(core_clk), .rst_in(rst), .ck_in(ck), .reset_n_in(rst_n),
    .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]),
    .we_n_in(cmd[0]), .ba_in(ba), .addr_in(addr), .odt_in(odt),
    .dm_in(dm), .dq_in(dq), .dq_out(dq_o), .dq_oe_out(dq_oe),
    .dqs_out(dqs), .dqs_n_out(dqs_n), .dqs_oe_out(dqs_oe),
    .term_en_out(term), .tdqs_term_out(tdqs), .rd_data_in(rd_pat),
    .wr_data_out(wr_data), .wr_be_out(wr_be), .wr_valid_out(wr_valid),
    .cmd_valid_out(cmd_valid), .cmd_kind_out(cmd_kind),
    .cmd_bank_out(cmd_bank), .cmd_addr_out(cmd_addr), .cmd_ap_out(cmd_ap),
    .cmd_chop_out(cmd_chop), .pwr_state_out(pwr));

  ddr3_ctl_model ctl (
    .ck_in(ck), .reset_n_out(rst_n), .cke_out(cke), .cs_n_out(cs_n),
    .cmd_out(cmd), .ba_out(ba), .addr_out(addr), .odt_out(odt),
    .dm_out(dm), .dq_out(dq));

  // Collect write beats; judge each read beat and its strobe toggle
  always @(posedge ck) begin
    if (wr_valid === 1'b1) wq.push_back({wr_be, wr_data});
    if (dq_oe === 1'b1) begin
      rcnt++;
      if (dq_o !== rd_pat || dqs_n !== ~dqs || dqs === dqs_prev ||
          dqs_oe !== 1'b1) rbad++;
    end
    dqs_prev = dqs;
  end

  // ---------------------------------------------------------------
  // Compare, report and closing tasks
  // ---------------------------------------------------------------
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_p(input pwr_t got, input pwr_t exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t power %h expected %h", $time, got, exp);
    end
  endtask : chk_p

  task automatic end_sim();
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // Bounded wait for the core report of the last command
  task automatic rep(input cmd_t k, input logic [2:0] b,
                     input logic [13:0] a);
    int n;
    n = 0;
    while (cmd_valid !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk_v(16'({cmd_valid, cmd_kind, cmd_bank}), 16'({1'b1, k, b}));
    chk_v(16'(cmd_addr), 16'(a));
  endtask : rep

  // Power state settles in a few core cycles after the link change
  task automatic pw(input pwr_t e);
    repeat (10) @(posedge core_clk);
    chk_p(pwr, e);
  endtask : pw

  // Write to bank 3: n beats, beat 1 masked if m, tq when masks are off
  task automatic wr(input logic [13:0] a, input int n, input logic m,
                    input logic tq);
    wq.delete();
    ctl.issue(1'b0, CMD_WR, 3'h3, a, 1'b1);
    for (int i = 0; i < n; i++) ctl.beat(8'h10 + 8'(i), m && i == 1);
    repeat (4) ctl.nop();
    chk_v(16'(wq.size()), 16'(n));
    foreach (wq[i])
      chk_v(16'(wq[i]), 16'({tq || !(m && i == 1), 8'h10 + 8'(i)}));
    chk_v(16'({cmd_kind, cmd_ap, cmd_chop}),
          16'({CMD_WR, a[AP_BIT], n == 4}));
  endtask : wr

  task automatic rd(input logic sel_n, input logic [13:0] a, input int n);
    rcnt = 0;
    rbad = 0;
    ctl.issue(sel_n, CMD_RD, 3'h3, a, 1'b1);
    repeat (n + 4) ctl.nop();
    chk_v(16'(rcnt), 16'(n));
    chk_v(16'(rbad), 16'h0000);
  endtask : rd

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_mode();
    ctl.issue(1'b0, CMD_MRS, 3'h0, 14'h0001, 1'b1);
    ctl.nop();
    rep(CMD_MRS, 3'h0, 14'h0001);
    ctl.issue(1'b0, CMD_MRS, 3'h1, 14'h0004, 1'b1);
    ctl.pins(1'b1, 1'b1, 1'b1);
    repeat (6) ctl.nop();
    chk_v(16'({term, tdqs}), 16'h0002);
    ctl.issue(1'b0, CMD_MRS, 3'h1, 14'h0000, 1'b1);
    repeat (6) ctl.nop();
    chk_v(16'(term), 16'h0000);
    ctl.pins(1'b1, 1'b1, 1'b0);
  endtask : t_mode

  task automatic t_data();
    ctl.issue(1'b0, CMD_ACT, 3'h3, 14'h1abc, 1'b1);
    ctl.nop();
    rep(CMD_ACT, 3'h3, 14'h1abc);
    wr(14'h0000, 4, 1'b1, 1'b0);
    wr(14'h1000, 8, 1'b1, 1'b0);
    rd(1'b0, 14'h1000, 8);
    rd(1'b0, 14'h0000, 4);
    rd(1'b1, 14'h1000, 0);
    ctl.pins(1'b1, 1'b1, 1'b1);
    ctl.issue(1'b0, CMD_MRS, 3'h1, 14'h0804, 1'b1);
    repeat (3) ctl.nop();
    chk_v(16'({term, tdqs}), 16'h0003);
    wr(14'h1000, 8, 1'b1, 1'b1);
    ctl.issue(1'b0, CMD_MRS, 3'h1, 14'h0000, 1'b1);
    ctl.nop();
  endtask : t_data

  task automatic t_pwr();
    ctl.pins(1'b1, 1'b0, 1'b0);
    pw(PWR_APD);
    rcnt = 0;
    ctl.issue(1'b0, CMD_RD, 3'h3, 14'h1000, 1'b0);
    repeat (12) ctl.nop();
    chk_v(16'(rcnt), 16'h0000);
    ctl.pins(1'b1, 1'b1, 1'b0);
    pw(PWR_ON);
    ctl.issue(1'b0, CMD_ACT, 3'h5, 14'h0000, 1'b1);
    ctl.issue(1'b0, CMD_PRE, 3'h3, 14'h0000, 1'b1);
    ctl.issue(1'b1, CMD_NOP, 3'h0, 14'h0000, 1'b0);
    pw(PWR_APD);
    ctl.pins(1'b1, 1'b1, 1'b0);
    ctl.issue(1'b0, CMD_PRE, 3'h0, 14'h0400, 1'b1);
    ctl.issue(1'b1, CMD_NOP, 3'h0, 14'h0000, 1'b0);
    pw(PWR_PPD);
    ctl.pins(1'b1, 1'b1, 1'b0);
    ctl.issue(1'b0, CMD_REF, 3'h0, 14'h0000, 1'b0);
    ctl.nop();
    pw(PWR_SR);
    ctl.pins(1'b1, 1'b1, 1'b0);
    pw(PWR_ON);
    ctl.issue(1'b0, CMD_ACT, 3'h3, 14'h0000, 1'b1);
    repeat (6) ctl.nop();
    wr(14'h0400, 4, 1'b0, 1'b0);
    ctl.issue(1'b1, CMD_NOP, 3'h0, 14'h0000, 1'b0);
    pw(PWR_PPD);
    ctl.pins(1'b1, 1'b1, 1'b0);
  endtask : t_pwr

  // Device reset in mid-run with a row open
  task automatic t_rst();
    ctl.issue(1'b0, CMD_ACT, 3'h4, 14'h0000, 1'b1);
    ctl.nop();
    ctl.pins(1'b0, 1'b1, 1'b0);
    pw(PWR_ON);
    chk_v(16'({dq_oe, dqs_n, term}), 16'h0002);
    ctl.pins(1'b1, 1'b1, 1'b0);
    ctl.issue(1'b1, CMD_NOP, 3'h0, 14'h0000, 1'b0);
    pw(PWR_PPD);
  endtask : t_rst

  // Main sequence: reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    ctl.pins(1'b1, 1'b1, 1'b0);
    repeat (4) ctl.nop();
    chk_v(16'({dq_oe, dqs_n, cmd_valid}), 16'h0002);
    pw(PWR_ON);
    t_mode();
    t_data();
    t_pwr();
    t_rst();
    end_sim();
  end

  // Watchdog far beyond the few microseconds the scenarios need
  initial begin
    #200000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule : ddr3_pin_command_interface_tb_top
